// *** rtl/phy_basic_mode_control.v ***
// How it works
// - Self-clearing bits set on event, clear after
// - Strapped fields load from pins after reset
// - Fixed read-only fields ignore writes
// - Reset bit reads one, self-clears, restraps
// - Loopback routes MII transmit onto receive
// - Speed code bits six and thirteen
// - Auto-negotiation enable overrides manual speed, duplex
// - Power-down bit powers down, management stays
// - Power-down is bit OR pin; pin sets
// - Isolate cuts MII, keeps management
// - Restart bit triggers negotiation, self-clears
// - Writing zero to restart is harmless
// - Duplex bit selects full or half
// - Collision test echoes transmit enable
// - Bits five to zero read zero
// - Reset values of the fixed fields
// - Software reset touches standard registers only
// - Management works while powered down
`timescale 1ns/1ps
`include "basic_mode_consts.vh"

module phy_basic_mode_control #(
  parameter RESET_CYCLES = `SW_RESET_CYCLES  // Software reset hold time in clocks
) (
  input  wire       ref_clk_in,
  input  wire       nrst_in,
  input  wire       mdc_in,
  input  wire       mdio_in,
  output reg        mdio_out,
  output reg        mdio_oe_n_out,
  input  wire [4:0] phy_addr_strap_in,
  input  wire       an_strap_in,
  input  wire       duplex_strap_in,
  input  wire       power_down_pin_n_in,
  input  wire       mii_tx_en_in,
  input  wire [7:0] mii_txd_in,
  input  wire       line_rx_dv_in,
  input  wire [7:0] line_rxd_in,
  input  wire       line_col_in,
  output reg        mii_rx_dv_out,
  output reg  [7:0] mii_rxd_out,
  output reg        mii_col_out,
  output reg        line_tx_en_out,
  output reg  [7:0] line_txd_out,
  input  wire       an_started_in,
  input  wire [1:0] an_speed_in,
  input  wire       an_duplex_in,
  output wire       an_restart_out,
  output wire [1:0] speed_out,
  output wire       full_duplex_out,
  output wire       speed_reserved_out,
  output wire       power_down_out,
  output wire       isolate_out,
  output wire       loopback_out,
  output wire       std_reset_out,
  output reg        mgmt_read_out
);

  // Frame decoder states
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_HDR  = 2'h1;
  localparam [1:0] S_TA   = 2'h2;
  localparam [1:0] S_DATA = 2'h3;

  // Control fields
  reg        loopback;        // Loopback enable
  reg        speed_lsb;       // Manual speed low bit
  reg        an_enable;       // Auto-negotiation enable
  reg        power_down;      // Power-down request bit
  reg        isolate;         // Isolate enable
  reg        an_restart;      // Restart pending, self-clearing
  reg        duplex;          // Manual duplex
  reg        col_test;        // Collision test enable
  reg        speed_msb;       // Manual speed high bit
  // Software reset and strap capture
  reg        reset_busy;      // Software reset in progress
  reg [15:0] reset_cnt;       // Cycles left in software reset
  reg        strap_pending;   // Straps still to be captured
  reg [4:0]  phy_addr;        // Captured physical address
  // Management frame decoder
  reg        mdc_q;           // Previous sample of management clock
  reg [1:0]  state;           // Decoder state
  reg [5:0]  pre_cnt;         // Consecutive preamble ones
  reg [4:0]  bit_cnt;         // Bit counter within a field
  reg [12:0] hdr;             // Start, opcode, address bits
  reg [15:0] shreg;           // Data shift register
  reg        is_read;         // Frame is a read to this register
  reg        is_write;        // Frame is a write to this register
  reg        wr_commit;       // One-cycle pulse: write data complete
  reg [15:0] wr_data;         // Data of the completed write

  wire       mdc_rise = mdc_in & ~mdc_q;
  wire       addr_hit = (hdr[9:5] == phy_addr) && (hdr[4:0] == `BMC_REG_ADDR);
  wire [1:0] hdr_op   = hdr[11:10];

  // Read value; low reserved bits fixed at zero
  wire [15:0] rd_value = {reset_busy, loopback, speed_lsb, an_enable,
                          power_down, isolate, an_restart, duplex,
                          col_test, speed_msb, 6'h00};

  // Management clock edge detect
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc_in;
    end
  end

  // Clause 22 frame decoder, runs regardless of power state
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state         <= S_IDLE;
      pre_cnt       <= 6'h00;
      bit_cnt       <= 5'h00;
      hdr           <= 13'h0000;
      shreg         <= 16'h0000;
      is_read       <= 1'b0;
      is_write      <= 1'b0;
      wr_commit     <= 1'b0;
      wr_data       <= 16'h0000;
      mdio_out      <= 1'b1;
      mdio_oe_n_out <= 1'b1;
      mgmt_read_out <= 1'b0;
    end else begin
      wr_commit     <= 1'b0;
      mgmt_read_out <= 1'b0;
      if (mdc_rise) begin
        case (state)
          S_IDLE: begin
            // Count ones, a zero after a full preamble starts a frame
            if (mdio_in) begin
              if (pre_cnt != `MDIO_PREAMBLE_BITS) begin
                pre_cnt <= pre_cnt + 6'h01;
              end
            end else begin
              if (pre_cnt == `MDIO_PREAMBLE_BITS) begin
                state   <= S_HDR;
                bit_cnt <= 5'h00;
              end
              pre_cnt <= 6'h00;
            end
          end
          S_HDR: begin
            // Shift in second start bit, opcode, both addresses
            hdr     <= {hdr[11:0], mdio_in};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h0C) begin
              state   <= S_TA;
              bit_cnt <= 5'h00;
            end
          end
          S_TA: begin
            if (bit_cnt == 5'h00) begin
              // Header complete; decide and take the read snapshot
              is_read  <= hdr[12] && hdr_op == `MDIO_OP_READ && addr_hit;
              is_write <= hdr[12] && hdr_op == `MDIO_OP_WRITE && addr_hit;
              if (!hdr[12]) begin
                state <= S_IDLE;
              end else begin
                bit_cnt <= 5'h01;
              end
              if (hdr[12] && hdr_op == `MDIO_OP_READ && addr_hit) begin
                shreg         <= rd_value;
                mgmt_read_out <= 1'b1;
                mdio_out      <= 1'b0;
                mdio_oe_n_out <= 1'b0;
              end
            end else begin
              // Second turnaround bit done, first data bit out
              state   <= S_DATA;
              bit_cnt <= 5'h00;
              if (is_read) begin
                mdio_out <= shreg[15];
                shreg    <= {shreg[14:0], 1'b0};
              end
            end
          end
          S_DATA: begin
            bit_cnt <= bit_cnt + 5'h01;
            if (is_read) begin
              mdio_out <= shreg[15];
              shreg    <= {shreg[14:0], 1'b0};
            end else begin
              shreg <= {shreg[14:0], mdio_in};
            end
            if (bit_cnt == 5'h0F) begin
              // Frame ends: release the line, commit a write
              state         <= S_IDLE;
              mdio_out      <= 1'b1;
              mdio_oe_n_out <= 1'b1;
              if (is_write) begin
                wr_commit <= 1'b1;
                wr_data   <= {shreg[14:0], mdio_in};
              end
              is_read  <= 1'b0;
              is_write <= 1'b0;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Control register fields, software reset and strap capture
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      loopback      <= `BMC_RST_OTHER;
      speed_lsb     <= `BMC_RST_OTHER;
      an_enable     <= 1'b0;
      power_down    <= `BMC_RST_OTHER;
      isolate       <= `BMC_RST_OTHER;
      an_restart    <= 1'b0;
      duplex        <= 1'b0;
      col_test      <= `BMC_RST_OTHER;
      speed_msb     <= `BMC_RST_SPEED_MSB;
      reset_busy    <= 1'b0;
      reset_cnt     <= 16'h0000;
      strap_pending <= 1'b1;
      phy_addr      <= 5'h00;
    end else if (strap_pending) begin
      // First clock after release or end of software reset
      strap_pending <= 1'b0;
      an_enable     <= an_strap_in;
      duplex        <= duplex_strap_in;
      if (!reset_busy) begin
        phy_addr <= phy_addr_strap_in;
      end
      reset_busy    <= 1'b0;
      power_down    <= ~power_down_pin_n_in;
    end else if (reset_busy) begin
      // Hold defaults while the standard registers reset
      loopback   <= `BMC_RST_OTHER;
      speed_lsb  <= `BMC_RST_OTHER;
      power_down <= `BMC_RST_OTHER;
      isolate    <= `BMC_RST_OTHER;
      an_restart <= 1'b0;
      col_test   <= `BMC_RST_OTHER;
      speed_msb  <= `BMC_RST_SPEED_MSB;
      if (reset_cnt == 16'h0000) begin
        strap_pending <= 1'b1;
      end else begin
        reset_cnt <= reset_cnt - 16'h0001;
      end
    end else begin
      if (wr_commit && wr_data[`BMC_SW_RESET]) begin
        // Reset write: other fields follow the defaults, not the data
        reset_busy <= 1'b1;
        reset_cnt  <= RESET_CYCLES[15:0] - 16'h0001;
      end else if (wr_commit) begin
        loopback  <= wr_data[`BMC_LOOPBACK];
        speed_lsb <= wr_data[`BMC_SPEED_LSB];
        an_enable <= wr_data[`BMC_AN_ENABLE];
        isolate   <= wr_data[`BMC_ISOLATE];
        duplex    <= wr_data[`BMC_DUPLEX];
        col_test  <= wr_data[`BMC_COL_TEST];
        speed_msb <= wr_data[`BMC_SPEED_MSB];
      end
      // Pin asserted sets the bit, over any write
      if (!power_down_pin_n_in) begin
        power_down <= 1'b1;
      end else if (wr_commit && !wr_data[`BMC_SW_RESET]) begin
        power_down <= wr_data[`BMC_POWER_DOWN];
      end
      // Restart: a one with negotiation on sets; zero never clears
      if (wr_commit && wr_data[`BMC_SW_RESET] == 1'b0 &&
          wr_data[`BMC_AN_RESTART] && wr_data[`BMC_AN_ENABLE]) begin
        an_restart <= 1'b1;
      end else if (an_started_in || !an_enable) begin
        an_restart <= 1'b0;
      end
    end
  end

  // MII data path: loopback, isolate, collision test, all registered
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mii_rx_dv_out  <= 1'b0;
      mii_rxd_out    <= 8'h00;
      mii_col_out    <= 1'b0;
      line_tx_en_out <= 1'b0;
      line_txd_out   <= 8'h00;
    end else if (isolate || power_down_out) begin
      // Port cut off from the MAC side
      mii_rx_dv_out  <= 1'b0;
      mii_rxd_out    <= 8'h00;
      mii_col_out    <= 1'b0;
      line_tx_en_out <= 1'b0;
      line_txd_out   <= 8'h00;
    end else if (loopback) begin
      // Transmit echoed back, nothing sent to the line
      mii_rx_dv_out  <= mii_tx_en_in;
      mii_rxd_out    <= mii_txd_in;
      mii_col_out    <= col_test & mii_tx_en_in;
      line_tx_en_out <= 1'b0;
      line_txd_out   <= 8'h00;
    end else begin
      mii_rx_dv_out  <= line_rx_dv_in;
      mii_rxd_out    <= line_rxd_in;
      mii_col_out    <= col_test ? mii_tx_en_in : line_col_in;
      line_tx_en_out <= mii_tx_en_in;
      line_txd_out   <= mii_txd_in;
    end
  end

  // Resolved operating mode
  assign speed_out          = an_enable ? an_speed_in
                                        : {speed_msb, speed_lsb};
  assign full_duplex_out    = an_enable ? an_duplex_in : duplex;
  assign speed_reserved_out = ~an_enable &&
                              ({speed_msb, speed_lsb} == `SPEED_RESERVED);
  assign power_down_out     = power_down | ~power_down_pin_n_in;
  assign isolate_out        = isolate;
  assign loopback_out       = loopback;
  assign an_restart_out     = an_restart & an_enable & ~reset_busy;
  assign std_reset_out      = reset_busy;

endmodule // phy_basic_mode_control

// *** common/basic_mode_consts.vh ***
`ifndef BASIC_MODE_CONSTS_VH
`define BASIC_MODE_CONSTS_VH

// Register index of the control word in the management address space
`define BMC_REG_ADDR        5'h00

// Field positions inside the control word
`define BMC_SW_RESET        15
`define BMC_LOOPBACK        14
`define BMC_SPEED_LSB       13
`define BMC_AN_ENABLE       12
`define BMC_POWER_DOWN      11
`define BMC_ISOLATE         10
`define BMC_AN_RESTART      9
`define BMC_DUPLEX          8
`define BMC_COL_TEST        7
`define BMC_SPEED_MSB       6

// Fixed reset values of the non-strapped fields
`define BMC_RST_SPEED_MSB   1'b1
`define BMC_RST_OTHER       1'b0

// Speed codes, high bit then low bit
`define SPEED_10            2'h0
`define SPEED_100           2'h1
`define SPEED_1000          2'h2
`define SPEED_RESERVED      2'h3

// Management frame opcodes and preamble length
`define MDIO_OP_WRITE       2'h1
`define MDIO_OP_READ        2'h2
`define MDIO_PREAMBLE_BITS  6'h20

// Software reset duration and clock period
`define SW_RESET_NS         1000
`define CLK_PERIOD_NS       10
`define SW_RESET_CYCLES     ((`SW_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** tb/phy_mode_checker.sv ***
`timescale 1ns/1ps
// Port-level checks of the control word behaviour
module phy_mode_checker #(
  parameter RESET_CYCLES = 100
) (
  input wire       ref_clk_in,
  input wire       nrst_in,
  input wire       power_down_pin_n_in,
  input wire       mii_tx_en_in,
  input wire [7:0] mii_txd_in,
  input wire       an_started_in,
  input wire [1:0] an_speed_in,
  input wire       an_duplex_in,
  input wire       mdio_out,
  input wire       mdio_oe_n_out,
  input wire       mii_rx_dv_out,
  input wire [7:0] mii_rxd_out,
  input wire       mii_col_out,
  input wire       line_tx_en_out,
  input wire       an_restart_out,
  input wire [1:0] speed_out,
  input wire       full_duplex_out,
  input wire       power_down_out,
  input wire       isolate_out,
  input wire       loopback_out,
  input wire       std_reset_out,
  input wire       mgmt_read_out
);
  reg [15:0] rst_cnt; // Cycles spent in software reset
  // Count the software reset length
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) rst_cnt <= 16'h0000;
    else if (std_reset_out) rst_cnt <= rst_cnt + 16'h0001;
    else rst_cnt <= 16'h0000;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  pin_power_a: assert property (!power_down_pin_n_in |-> power_down_out)
    else $error("pin did not force power down");
  iso_zero_a: assert property (isolate_out |=> !mii_rx_dv_out && !mii_col_out
    && mii_rxd_out == 8'h00 && !line_tx_en_out) else $error("isolate leak");
  pd_zero_a: assert property (power_down_out |=> !mii_rx_dv_out && !line_tx_en_out)
    else $error("power down leak");
  loop_route_a: assert property (loopback_out && !isolate_out && !power_down_out |=>
    mii_rxd_out == $past(mii_txd_in) && mii_rx_dv_out == $past(mii_tx_en_in)
    && !line_tx_en_out) else $error("loopback route wrong");
  an_override_a: assert property (an_restart_out |-> speed_out == an_speed_in
    && full_duplex_out == an_duplex_in) else $error("manual bits used");
  restart_clear_a: assert property (an_restart_out && an_started_in |=>
    !an_restart_out) else $error("restart not cleared");
  ta_zero_a: assert property ($fell(mdio_oe_n_out) |-> !mdio_out)
    else $error("turnaround not zero");
  read_pulse_a: assert property (mgmt_read_out |=> !mgmt_read_out && !mdio_oe_n_out)
    else $error("read pulse wrong");
  swrst_len_a: assert property ($fell(std_reset_out) |-> rst_cnt >= RESET_CYCLES
    && rst_cnt <= RESET_CYCLES + 2) else $error("reset length wrong");
  swrst_dflt_a: assert property (std_reset_out |-> !loopback_out && !an_restart_out)
    else $error("defaults not held");
endmodule // phy_mode_checker

bind phy_basic_mode_control phy_mode_checker #(.RESET_CYCLES(RESET_CYCLES)) chk (
  .ref_clk_in, .nrst_in, .power_down_pin_n_in, .mii_tx_en_in, .mii_txd_in,
  .an_started_in, .an_speed_in, .an_duplex_in, .mdio_out, .mdio_oe_n_out,
  .mii_rx_dv_out, .mii_rxd_out, .mii_col_out, .line_tx_en_out, .an_restart_out,
  .speed_out, .full_duplex_out, .power_down_out, .isolate_out, .loopback_out,
  .std_reset_out, .mgmt_read_out);

// *** tb/smi_master.sv ***
`timescale 1ns/1ps
// Management station: clock stands low and line idles high between frames
module smi_master (
  input  wire clk_in,
  input  wire mdio_wire_in,
  output reg  mdc_out,
  output reg  mdio_out
);
  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
  end
  // Whole frame; line released (pulled high) in turnaround and read data
  task xfer(input [1:0] op, input [4:0] pa, input [15:0] wd, output [15:0] rd);
    reg [63:0] f;
    integer    i;
    begin
      f = {32'hFFFF_FFFF, 2'b01, op, pa, 5'h00, op[0] ? 2'b10 : 2'b11, wd};
      for (i = 63; i >= 0; i = i - 1) begin
        @(negedge clk_in);
        mdc_out = 1'b0;
        mdio_out = f[i];
        repeat (3) @(negedge clk_in);
        rd = {rd[14:0], mdio_wire_in};
        mdc_out = 1'b1;
        repeat (3) @(negedge clk_in);
      end
      @(negedge clk_in);
      mdc_out = 1'b0;
      mdio_out = 1'b1;
      repeat (8) @(negedge clk_in);
    end
  endtask
endmodule // smi_master

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "basic_mode_consts.vh"
`define CHK(a, e) begin tests_run = tests_run + 1; if ((a) !== (e)) begin \
  failures = failures + 1; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  localparam       RST_CYC = 40;
  localparam [4:0] PA      = 5'h0A;
  reg        ref_clk_in, nrst_in, an_strap_in, duplex_strap_in;
  reg        power_down_pin_n_in, mii_tx_en_in, an_started_in, an_duplex_in;
  reg  [1:0] an_speed_in;
  reg  [7:0] mii_txd_in;
  wire       mdc_in, drv, mdio_out, mdio_oe_n_out, mii_rx_dv_out, mii_col_out;
  wire       line_tx_en_out, an_restart_out, full_duplex_out, speed_reserved_out;
  wire       power_down_out, isolate_out, loopback_out, std_reset_out, mgmt_read_out;
  wire [1:0] speed_out;
  wire [7:0] mii_rxd_out, line_txd_out;
  wire       mdio_in = mdio_oe_n_out ? drv : mdio_out; // Device wins when driving
  integer    failures, tests_run, i;
  reg [15:0] r, d;
  phy_basic_mode_control #(.RESET_CYCLES(RST_CYC)) dut (
    .ref_clk_in, .nrst_in, .mdc_in, .mdio_in, .mdio_out, .mdio_oe_n_out,
    .phy_addr_strap_in(PA), .an_strap_in, .duplex_strap_in, .power_down_pin_n_in,
    .mii_tx_en_in, .mii_txd_in, .line_rx_dv_in(1'b1), .line_rxd_in(8'h3C),
    .line_col_in(1'b0), .mii_rx_dv_out, .mii_rxd_out, .mii_col_out, .line_tx_en_out,
    .line_txd_out, .an_started_in, .an_speed_in, .an_duplex_in, .an_restart_out,
    .speed_out, .full_duplex_out, .speed_reserved_out, .power_down_out, .isolate_out,
    .loopback_out, .std_reset_out, .mgmt_read_out);
  smi_master smi (.clk_in(ref_clk_in), .mdio_wire_in(mdio_in), .mdc_out(mdc_in),
    .mdio_out(drv));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task wr(input [15:0] v);
    smi.xfer(`MDIO_OP_WRITE, PA, v, r);
  endtask
  task rd(input [15:0] e);
    begin
      smi.xfer(`MDIO_OP_READ, PA, 16'hFFFF, r);
      `CHK(r, e)
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    failures = failures + 1;
    summarize;
  end
  initial begin
    failures = 0;
    tests_run = 0;
    nrst_in = 1'b0;
    an_strap_in = 1'b0;
    duplex_strap_in = 1'b1;
    power_down_pin_n_in = 1'b1;
    mii_tx_en_in = 1'b1;
    mii_txd_in = 8'hA5;
    an_started_in = 1'b0;
    an_duplex_in = 1'b0;
    an_speed_in = `SPEED_1000;
    tick(5);
    nrst_in = 1'b1;
    tick(4);
    `CHK({mii_rxd_out, line_txd_out}, 16'h3CA5)
    rd(16'h0140);
    wr(16'h61BF);
    tick(2); // Host leaves loopback time to settle
    rd(16'h6180);
    `CHK({speed_out, full_duplex_out}, {`SPEED_100, 1'b1})
    `CHK({mii_rx_dv_out, mii_rxd_out, line_tx_en_out}, 10'h34A)
    `CHK(mii_col_out, 1'b1)
    mii_tx_en_in = 1'b0;
    tick(2);
    `CHK(mii_col_out, 1'b0)
    mii_tx_en_in = 1'b1;
    // Every manual speed code, half duplex throughout
    for (i = 0; i < 4; i = i + 1) begin
      d = 16'h0000;
      d[13] = i[0];
      d[6] = i[1];
      wr(d);
      if (i < 3) `CHK(speed_out, i[1:0])
      `CHK({speed_reserved_out, full_duplex_out}, {i == 3, 1'b0})
    end
    wr(16'h0400);
    `CHK({isolate_out, mii_rx_dv_out, line_tx_en_out}, 3'b100)
    power_down_pin_n_in = 1'b0;
    tick(2);
    `CHK(power_down_out, 1'b1)
    rd(16'h0C00);
    power_down_pin_n_in = 1'b1;
    rd(16'h0C00);
    wr(16'h0000);
    `CHK(power_down_out, 1'b0)
    wr(16'h0800);
    `CHK({power_down_out, isolate_out, mii_rx_dv_out, line_tx_en_out}, 4'h8)
    wr(16'h0200);
    rd(16'h0000);
    wr(16'h3300);
    `CHK({an_restart_out, speed_out, full_duplex_out}, {1'b1, `SPEED_1000, 1'b0})
    wr(16'h3100);
    `CHK(an_restart_out, 1'b1)
    an_started_in = 1'b1;
    tick(1);
    an_started_in = 1'b0;
    rd(16'h3100);
    smi.xfer(`MDIO_OP_READ, PA ^ 5'h01, 16'hFFFF, r);
    `CHK(r, 16'hFFFF)
    an_strap_in = 1'b1;
    wr(16'h8000);
    `CHK(std_reset_out, 1'b1)
    tick(RST_CYC + 4);
    `CHK(std_reset_out, 1'b0)
    rd(16'h1140);
    summarize;
  end
endmodule // tb
